// ===== cfgl_pkg.sv
// Function
// - logic stays inactive until the configuration memory is loaded from a bitstream.
// - active mode clocks the flash from an internal divider or the external clock pin.
// - active mode acts as flash master, driving instruction and address itself.
// - the first flash transaction is the release-from-power-down instruction.
// - at least 30 us pass between the wake instruction and the fast read.
// - fast read starts at flash address zero and reads sequentially.
// - jtag mode loads the bitstream serially over one test data line.
// - passive x16 and x32 are refused while security mode is enabled.
package cfgl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int WAKE_GAP_US  = 30;
  localparam int WAKE_GAP_CYC = WAKE_GAP_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // flash command frame
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_WAKE          = 8'hAB;
  localparam logic [7:0]  OP_FAST_READ     = 8'h0B;
  localparam logic [23:0] FLASH_START_ADDR = 24'h00_0000;
  localparam logic [7:0]  DUMMY_BYTE       = 8'h00;
  localparam logic [5:0]  WAKE_BITS        = 6'h08;
  localparam logic [5:0]  CMD_BITS         = 6'h28;
  localparam int          WORD_BITS        = 32;

  // ----------------------------------------------------------------
  // strap encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ACTIVE  = 2'h0;
  localparam logic [1:0] MODE_PASSIVE = 2'h1;
  localparam logic [1:0] MODE_JTAG    = 2'h2;
  localparam logic [2:0] WIDTH_X1     = 3'h0;
  localparam logic [2:0] WIDTH_X8     = 3'h3;
  localparam logic [2:0] WIDTH_X32    = 3'h5;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAKE, ST_GAP, ST_CMD, ST_READ, ST_PASSIVE, ST_JTAG, ST_FLUSH, ST_USER, ST_ERROR
  } cfgl_state_t;

  // every pin that arrives from outside the clock domain
  typedef struct packed {
    logic        cfg_rst_n;
    logic [1:0]  mode;
    logic [2:0]  width;
    logic        clk_sel;
    logic        secure;
    logic        ext_clk;
    logic        p_clk;
    logic        p_cs_n;
    logic [31:0] p_data;
    logic        tck;
    logic        tdi;
    logic        jtag_load;
    logic [7:0]  fdq;
  } cfgl_pins_t;

endpackage : cfgl_pkg

// ===== cfgl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             clr,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t      q;
  fifo_state_t      d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // pointers carry one extra bit so full and empty stay distinct
  assign in_ready  = (q.wr[AW] == q.rd[AW]) || (q.wr[AW-1:0] != q.rd[AW-1:0]);
  assign out_valid = (q.wr != q.rd);
  assign out_data  = mem[q.rd[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    if (clr) begin
      d = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wr[AW-1:0]] <= in_data;
    end
  end
endmodule : cfgl_fifo
`default_nettype wire

// ===== cfgl_loader.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_loader #(
  parameter int BITSTREAM_WORDS = 1024,
  parameter int SPI_DIV         = 8,
  parameter int FIFO_DEPTH      = 16,
  parameter int CM_AW           = 16
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             NRST,
  // configuration reset and straps
  input  wire logic             CONFIG_RESET_N,
  input  wire logic [1:0]       MODE,
  input  wire logic [2:0]       WIDTH,
  input  wire logic             CLK_SEL,
  input  wire logic             SECURE,
  input  wire logic             EXTERNAL_CONFIG_CLOCK_PIN,
  // active mode flash
  output logic                  FLASH_SCK,
  output logic                  FLASH_CS_N,
  output logic                  FLASH_MOSI,
  output logic                  FLASH_MOSI_OE,
  input  wire logic [7:0]       FLASH_DQ_IN,
  // passive mode master
  input  wire logic             PASV_CLK,
  input  wire logic             PASV_CS_N,
  input  wire logic [31:0]      PASV_DATA,
  // jtag loading
  input  wire logic             JTAG_TCK,
  input  wire logic             JTAG_TDI,
  input  wire logic             JTAG_LOAD,
  // configuration memory write port
  output logic                  CONFIG_MEMORY_WE,
  output logic [CM_AW-1:0]      CONFIG_MEMORY_ADDR,
  output logic [31:0]           CONFIG_MEMORY_DATA,
  input  wire logic             CONFIG_MEMORY_READY,
  // status
  output logic                  USER_MODE,
  output logic                  CONFIG_BUSY,
  output logic                  CONFIG_ERROR
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cfgl_pkg::cfgl_pins_t s1;
    cfgl_pkg::cfgl_pins_t s2;
    cfgl_pkg::cfgl_pins_t s3;
    cfgl_pkg::cfgl_pins_t pin;
    cfgl_pkg::cfgl_state_t st;
    logic [1:0]           mode;
    logic [2:0]           width;
    logic                 clk_sel;
    logic [15:0]          div;
    logic                 sck;
    logic                 cs_n;
    logic                 mosi;
    logic                 mosi_oe;
    logic [39:0]          tx;
    logic [5:0]           bitcnt;
    logic [15:0]          wait_cnt;
    logic [31:0]          shreg;
    logic [5:0]           fill;
    logic                 wvalid;
    logic [31:0]          wdata;
    logic [31:0]          words;
    logic                 cm_we;
    logic [CM_AW-1:0]     cm_addr;
    logic [CM_AW-1:0]     cm_next;
    logic [31:0]          cm_data;
    logic                 user;
    logic                 busy;
    logic                 err;
  } ldr_state_t;

  ldr_state_t           q;
  ldr_state_t           d;
  cfgl_pkg::cfgl_pins_t pins_in;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [31:0]          fifo_out_data;
  logic                 fifo_take;

  assign pins_in = '{cfg_rst_n: CONFIG_RESET_N, mode: MODE, width: WIDTH, clk_sel: CLK_SEL,
                     secure: SECURE, ext_clk: EXTERNAL_CONFIG_CLOCK_PIN, p_clk: PASV_CLK,
                     p_cs_n: PASV_CS_N, p_data: PASV_DATA, tck: JTAG_TCK, tdi: JTAG_TDI,
                     jtag_load: JTAG_LOAD, fdq: FLASH_DQ_IN};

  assign fifo_take = fifo_out_valid && (!q.cm_we || CONFIG_MEMORY_READY);

  // ----------------------------------------------------------------
  // buffer between bit assembly and configuration memory
  // ----------------------------------------------------------------
  cfgl_fifo #(
    .WIDTH (cfgl_pkg::WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .clr       (!q.pin.cfg_rst_n),
    .in_valid  (q.wvalid),
    .in_ready  (fifo_in_ready),
    .in_data   (q.wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rst_rise;
    logic        tick;
    logic        sample;
    logic [31:0] bits;
    logic [5:0]  lanes;
    logic [31:0] sh;
    logic        last;
    rst_rise = 1'b0;
    tick     = 1'b0;
    sample   = 1'b0;
    bits     = '0;
    lanes    = '0;
    sh       = '0;
    last     = 1'b0;
    d        = q;

    // three-stage sampling; a bit changes once stages two and three agree
    d.s1  = pins_in;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.pin = cfgl_pkg::cfgl_pins_t'((q.s2 & q.s3) | (q.pin & (q.s2 ^ q.s3)));
    rst_rise = !q.pin.cfg_rst_n && d.pin.cfg_rst_n;

    // spi clock source: internal divider or either edge of the external pin
    d.div = (q.div == 16'(SPI_DIV - 1)) ? '0 : q.div + 16'h0001;
    if (q.clk_sel) begin
      tick = q.pin.ext_clk ^ d.pin.ext_clk;
    end else begin
      tick = (q.div == 16'(SPI_DIV - 1));
    end
    // a word waiting for the buffer holds the flash clock still
    tick  = tick && !q.wvalid;
    lanes = 6'h01 << q.width;

    if (q.wvalid && fifo_in_ready) begin
      d.wvalid = 1'b0;
    end

    unique case (q.st)
      cfgl_pkg::ST_IDLE: begin
        if (rst_rise) begin
          d.mode    = d.pin.mode;
          d.width   = d.pin.width;
          d.clk_sel = d.pin.clk_sel;
          d.busy    = 1'b1;
          d.err     = 1'b0;
          if (d.pin.mode == cfgl_pkg::MODE_ACTIVE && d.pin.width <= cfgl_pkg::WIDTH_X8) begin
            d.st      = cfgl_pkg::ST_WAKE;
            d.cs_n    = 1'b0;
            d.mosi_oe = 1'b1;
            d.tx      = {cfgl_pkg::OP_WAKE, 32'h0000_0000};
            d.mosi    = cfgl_pkg::OP_WAKE[7];
            d.bitcnt  = cfgl_pkg::WAKE_BITS;
          end else if (d.pin.mode == cfgl_pkg::MODE_PASSIVE && d.pin.width <= cfgl_pkg::WIDTH_X32
                       && !(d.pin.secure && d.pin.width > cfgl_pkg::WIDTH_X8)) begin
            d.st = cfgl_pkg::ST_PASSIVE;
          end else if (d.pin.mode == cfgl_pkg::MODE_JTAG) begin
            d.st    = cfgl_pkg::ST_JTAG;
            d.width = cfgl_pkg::WIDTH_X1;
          end else begin
            d.st   = cfgl_pkg::ST_ERROR;
            d.busy = 1'b0;
            d.err  = 1'b1;
          end
        end
      end
      cfgl_pkg::ST_WAKE, cfgl_pkg::ST_CMD: begin
        if (tick) begin
          if (!q.sck) begin
            d.sck = 1'b1;
          end else begin
            d.sck    = 1'b0;
            d.tx     = {q.tx[38:0], 1'b0};
            d.mosi   = q.tx[38];
            d.bitcnt = q.bitcnt - 6'h01;
            if (q.bitcnt == 6'h01) begin
              d.mosi = 1'b0;
              if (q.st == cfgl_pkg::ST_WAKE) begin
                d.st       = cfgl_pkg::ST_GAP;
                d.cs_n     = 1'b1;
                d.mosi_oe  = 1'b0;
                d.wait_cnt = '0;
              end else begin
                d.st      = cfgl_pkg::ST_READ;
                d.mosi_oe = 1'b0;
              end
            end
          end
        end
      end
      cfgl_pkg::ST_GAP: begin
        // counted from chip select rising, so the gap is never short
        d.wait_cnt = q.wait_cnt + 16'h0001;
        if (q.wait_cnt == 16'(cfgl_pkg::WAKE_GAP_CYC - 1)) begin
          d.st      = cfgl_pkg::ST_CMD;
          d.cs_n    = 1'b0;
          d.mosi_oe = 1'b1;
          d.tx      = {cfgl_pkg::OP_FAST_READ, cfgl_pkg::FLASH_START_ADDR,
                       cfgl_pkg::DUMMY_BYTE};
          d.mosi    = cfgl_pkg::OP_FAST_READ[7];
          d.bitcnt  = cfgl_pkg::CMD_BITS;
        end
      end
      cfgl_pkg::ST_READ: begin
        if (tick) begin
          d.sck = !q.sck;
          if (!q.sck) begin
            sample = 1'b1;
            bits   = {24'h00_0000, d.pin.fdq};
          end
        end
      end
      cfgl_pkg::ST_PASSIVE: begin
        // data is taken only on the master's rising clock with select low
        sample = !q.pin.p_clk && d.pin.p_clk && !d.pin.p_cs_n;
        bits   = d.pin.p_data;
      end
      cfgl_pkg::ST_JTAG: begin
        sample = !q.pin.tck && d.pin.tck && d.pin.jtag_load;
        bits   = {31'h0000_0000, d.pin.tdi};
      end
      cfgl_pkg::ST_FLUSH: begin
        if (!fifo_out_valid && !q.cm_we && !q.wvalid) begin
          d.st   = cfgl_pkg::ST_USER;
          d.user = 1'b1;
          d.busy = 1'b0;
        end
      end
      cfgl_pkg::ST_USER, cfgl_pkg::ST_ERROR: begin
      end
    endcase

    // ----------------------------------------------------------------
    // word assembly, msb first
    // ----------------------------------------------------------------
    if (sample) begin
      sh      = (q.shreg << lanes) | (bits & ~(32'hFFFF_FFFF << lanes));
      d.shreg = sh;
      d.fill  = q.fill + lanes;
      if (d.fill == 6'(cfgl_pkg::WORD_BITS)) begin
        d.fill  = '0;
        d.words = q.words + 32'h0000_0001;
        if (q.wvalid && !fifo_in_ready) begin
          // a master that cannot be stalled outran the buffer
          d.st   = cfgl_pkg::ST_ERROR;
          d.busy = 1'b0;
          d.err  = 1'b1;
        end else begin
          d.wvalid = 1'b1;
          d.wdata  = sh;
          last     = (d.words == 32'(BITSTREAM_WORDS));
        end
      end
    end
    if (last) begin
      d.st   = cfgl_pkg::ST_FLUSH;
      d.cs_n = 1'b1;
      d.sck  = 1'b0;
    end

    // ----------------------------------------------------------------
    // configuration memory writes
    // ----------------------------------------------------------------
    if (fifo_take) begin
      d.cm_we   = 1'b1;
      d.cm_data = fifo_out_data;
      d.cm_addr = q.cm_next;
      d.cm_next = q.cm_next + 1'b1;
    end else if (CONFIG_MEMORY_READY) begin
      d.cm_we = 1'b0;
    end

    // config reset low aborts any load and drops the logic out of use
    if (!d.pin.cfg_rst_n) begin
      d.st      = cfgl_pkg::ST_IDLE;
      d.user    = 1'b0;
      d.busy    = 1'b0;
      d.sck     = 1'b0;
      d.cs_n    = 1'b1;
      d.mosi    = 1'b0;
      d.mosi_oe = 1'b0;
      d.fill    = '0;
      d.words   = '0;
      d.wvalid  = 1'b0;
      d.cm_we   = 1'b0;
      d.cm_next = '0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q      <= '0;
      q.st   <= cfgl_pkg::ST_IDLE;
      q.cs_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign FLASH_SCK          = q.sck;
  assign FLASH_CS_N         = q.cs_n;
  assign FLASH_MOSI         = q.mosi;
  assign FLASH_MOSI_OE      = q.mosi_oe;
  assign CONFIG_MEMORY_WE   = q.cm_we;
  assign CONFIG_MEMORY_ADDR = q.cm_addr;
  assign CONFIG_MEMORY_DATA = q.cm_data;
  assign USER_MODE          = q.user;
  assign CONFIG_BUSY        = q.busy;
  assign CONFIG_ERROR       = q.err;
endmodule : cfgl_loader
`default_nettype wire

// ===== cfgl_loader_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_loader_checker #(
  parameter int CM_AW = 16
) (
  // clock and reset
  input wire logic             CLK,
  input wire logic             NRST,
  // straps
  input wire logic             CONFIG_RESET_N,
  input wire logic [1:0]       MODE,
  input wire logic [2:0]       WIDTH,
  input wire logic             SECURE,
  // flash
  input wire logic             FLASH_SCK,
  input wire logic             FLASH_CS_N,
  input wire logic             FLASH_MOSI,
  input wire logic             FLASH_MOSI_OE,
  // memory and status
  input wire logic             CONFIG_MEMORY_WE,
  input wire logic [CM_AW-1:0] CONFIG_MEMORY_ADDR,
  input wire logic [31:0]      CONFIG_MEMORY_DATA,
  input wire logic             CONFIG_MEMORY_READY,
  input wire logic             USER_MODE,
  input wire logic             CONFIG_BUSY,
  input wire logic             CONFIG_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ----
  // frame counting: cycles deselected, frames since the load began
  // ----
  logic        cs_q;
  logic [11:0] hi_q;
  logic [1:0]  nfr_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cs_q  <= 1'b1;
      hi_q  <= '0;
      nfr_q <= '0;
    end else begin
      cs_q  <= FLASH_CS_N;
      hi_q  <= !FLASH_CS_N ? '0 : (&hi_q ? hi_q : hi_q + 1'b1);
      nfr_q <= !CONFIG_RESET_N ? '0 : nfr_q + 2'(cs_q & ~FLASH_CS_N);
    end
  end
  property p_wake_first;
    $fell(FLASH_CS_N) && nfr_q == 2'h0 |-> FLASH_MOSI_OE && FLASH_MOSI;
  endproperty
  a_wake_first: assert property (p_wake_first)
    else $error("first flash frame lacks wake opcode");
  property p_gap;
    $fell(FLASH_CS_N) && nfr_q == 2'h1 |-> hi_q >= 12'hBB8;
  endproperty
  a_gap: assert property (p_gap)
    else $error("wake to read gap too short");
  property p_cs_idle;
    FLASH_CS_N |-> !FLASH_SCK && !FLASH_MOSI_OE;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("flash clocked or driven while deselected");
  property p_user_hold;
    !CONFIG_RESET_N [*8] |-> !USER_MODE && !CONFIG_BUSY;
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("active while config reset low");
  property p_busy_user;
    CONFIG_BUSY |-> !USER_MODE;
  endproperty
  a_busy_user: assert property (p_busy_user)
    else $error("user mode during loading");
  property p_we_hold;
    CONFIG_MEMORY_WE && !CONFIG_MEMORY_READY && CONFIG_RESET_N |=> CONFIG_MEMORY_WE
      && $stable(CONFIG_MEMORY_DATA) && $stable(CONFIG_MEMORY_ADDR);
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("memory write dropped before ready");
  property p_addr_seq;
    CONFIG_MEMORY_WE && CONFIG_MEMORY_READY ##1 CONFIG_MEMORY_WE
      |-> CONFIG_MEMORY_ADDR == CM_AW'($past(CONFIG_MEMORY_ADDR) + 1);
  endproperty
  a_addr_seq: assert property (p_addr_seq)
    else $error("memory address not sequential");
  property p_act_refuse;
    $rose(CONFIG_RESET_N) && MODE == 2'h0 && WIDTH > 3'h3 |-> ##[1:16] CONFIG_ERROR && FLASH_CS_N;
  endproperty
  a_act_refuse: assert property (p_act_refuse)
    else $error("wide active load not refused");
  property p_sec_refuse;
    $rose(CONFIG_RESET_N) && MODE == 2'h1 && SECURE && WIDTH[2] |-> ##[1:16] CONFIG_ERROR;
  endproperty
  a_sec_refuse: assert property (p_sec_refuse)
    else $error("secure wide passive load not refused");
  property p_slave_quiet;
    CONFIG_BUSY && MODE != 2'h0 |-> FLASH_CS_N;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("flash selected outside active mode");
endmodule : cfgl_loader_checker
bind cfgl_loader cfgl_loader_checker #(.CM_AW(CM_AW)) i_chk (
  .CLK(CLK), .NRST(NRST), .CONFIG_RESET_N(CONFIG_RESET_N), .MODE(MODE), .WIDTH(WIDTH),
  .SECURE(SECURE), .FLASH_SCK(FLASH_SCK), .FLASH_CS_N(FLASH_CS_N), .FLASH_MOSI(FLASH_MOSI),
  .FLASH_MOSI_OE(FLASH_MOSI_OE), .CONFIG_MEMORY_WE(CONFIG_MEMORY_WE),
  .CONFIG_MEMORY_ADDR(CONFIG_MEMORY_ADDR), .CONFIG_MEMORY_DATA(CONFIG_MEMORY_DATA),
  .CONFIG_MEMORY_READY(CONFIG_MEMORY_READY), .USER_MODE(USER_MODE),
  .CONFIG_BUSY(CONFIG_BUSY), .CONFIG_ERROR(CONFIG_ERROR));
`default_nettype wire

// ===== cfgl_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_flash_model (
  // spi side
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic [2:0] width,
  output logic [7:0]      dq
);
  logic [31:0] mem [16];
  logic [39:0] sh;
  logic [39:0] frames [$];
  int          lens [$];
  int          nb;
  int          p;
  time         t_hi;
  time         gap_ns;
  initial dq = 8'h00;
  always @(negedge cs_n) begin
    gap_ns = $time - t_hi;
    nb = 0;
    p = 0;
    sh = '0;
  end
  // released lines flip so a late sample never reads stale data
  // the first deassertion out of reset carries no frame
  always @(posedge cs_n) begin
    t_hi = $time;
    if (nb > 0) begin
      frames.push_back(sh);
      lens.push_back(nb);
    end
    dq = ~dq;
  end
  always @(posedge sck) if (!cs_n) begin
    if (nb < 40) sh = {sh[38:0], mosi};
    nb++;
  end
  // data lanes change on the falling clock, top lane carries the msb
  always @(negedge sck) if (!cs_n && nb >= 40) begin
    for (int k = 0; k < (1 << width); k++) begin
      int b;
      b = p + (1 << width) - 1 - k;
      dq[k] = mem[b / 32][31 - b % 32];
    end
    p += 1 << width;
  end
endmodule : cfgl_flash_model
`default_nettype wire

// ===== cfgl_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfgl_loader_tb;
  localparam int NW = 4;
  logic        CLK, NRST, CONFIG_RESET_N, CLK_SEL, SECURE, EXTERNAL_CONFIG_CLOCK_PIN;
  logic [1:0]  MODE;
  logic [2:0]  WIDTH;
  logic        FLASH_SCK, FLASH_CS_N, FLASH_MOSI, FLASH_MOSI_OE;
  logic [7:0]  FLASH_DQ_IN;
  logic        PASV_CLK, PASV_CS_N, JTAG_TCK, JTAG_TDI, JTAG_LOAD;
  logic [31:0] PASV_DATA, CONFIG_MEMORY_DATA;
  logic [15:0] CONFIG_MEMORY_ADDR;
  logic        CONFIG_MEMORY_WE, CONFIG_MEMORY_READY, USER_MODE, CONFIG_BUSY, CONFIG_ERROR;
  int          errors, num_checks, idx;
  logic [31:0] exp_q [$];
  cfgl_loader #(.BITSTREAM_WORDS(NW)) i_dut (.*);
  cfgl_flash_model i_flash (.sck(FLASH_SCK), .cs_n(FLASH_CS_N), .mosi(FLASH_MOSI),
    .width(WIDTH), .dq(FLASH_DQ_IN));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always begin
    repeat (9) @(negedge CLK);
    EXTERNAL_CONFIG_CLOCK_PIN = ~EXTERNAL_CONFIG_CLOCK_PIN;
  end
  // ----
  // memory side: random stalls, every accepted word compared
  // ----
  always @(negedge CLK) CONFIG_MEMORY_READY <= $urandom_range(3) != 0;
  always @(posedge CLK) if (CONFIG_MEMORY_WE === 1'b1 && CONFIG_MEMORY_READY) begin
    check(CONFIG_MEMORY_ADDR === 16'(idx) && idx < exp_q.size()
      && CONFIG_MEMORY_DATA === exp_q[idx], "memory write");
    idx++;
  end
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic results();
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic start(input logic [1:0] m, input logic [2:0] w, input logic c, input logic s);
    CONFIG_RESET_N = 1'b0;
    MODE = m;
    WIDTH = w;
    CLK_SEL = c;
    SECURE = s;
    exp_q.delete();
    idx = 0;
    for (int i = 0; i < NW; i++) begin
      exp_q.push_back($urandom());
      i_flash.mem[i] = exp_q[i];
    end
    repeat (12) @(negedge CLK);
    CONFIG_RESET_N = 1'b1;
    repeat (8) @(negedge CLK);
  endtask : start
  // passive master or jtag driver, top lane first
  task automatic feed(input int lanes, input logic jt);
    logic [31:0] w;
    PASV_CS_N = jt;
    JTAG_LOAD = jt;
    for (int i = 0; i < NW * 32 / lanes; i++) begin
      w = exp_q[i * lanes / 32] << (i * lanes % 32);
      PASV_DATA = w >> (32 - lanes);
      JTAG_TDI = w[31];
      repeat (6) @(negedge CLK);
      PASV_CLK = ~jt;
      JTAG_TCK = jt;
      repeat (6) @(negedge CLK);
      PASV_CLK = 1'b0;
      JTAG_TCK = 1'b0;
    end
    PASV_CS_N = 1'b1;
    JTAG_LOAD = 1'b0;
    PASV_DATA = ~PASV_DATA;
  endtask : feed
  task automatic finish_load(input logic err, input int lanes);
    int n;
    n = 0;
    while (USER_MODE !== 1'b1 && CONFIG_ERROR !== 1'b1 && n < 20000) begin
      @(negedge CLK);
      n++;
    end
    repeat (4) @(negedge CLK);
    check(USER_MODE === ~err && CONFIG_ERROR === err && CONFIG_BUSY === 1'b0
      && idx == (err ? 0 : NW), "load outcome");
    if (lanes == 0) check(i_flash.frames.size() == 0, "flash touched");
    else begin
      check(i_flash.frames.size() == 2 && i_flash.lens[0] == 8
        && i_flash.frames[0][7:0] === cfgl_pkg::OP_WAKE, "wake frame");
      check(i_flash.frames[1] === {cfgl_pkg::OP_FAST_READ, 24'h00_0000, 8'h00}
        && i_flash.lens[1] == 39 + NW * 32 / lanes, "read frame");
      check(i_flash.gap_ns >= 30_000, "wake gap");
    end
    i_flash.frames.delete();
    i_flash.lens.delete();
  endtask : finish_load
  initial begin
    #800_000;
    errors++;
    $display("Error at %0t: timeout", $time);
    results();
  end
  initial begin
    void'($urandom(32'h4f7a));
    {NRST, CONFIG_RESET_N, CLK_SEL, SECURE, EXTERNAL_CONFIG_CLOCK_PIN} = '0;
    {PASV_CLK, JTAG_TCK, JTAG_TDI, JTAG_LOAD, CONFIG_MEMORY_READY} = '0;
    PASV_CS_N = 1'b1;
    PASV_DATA = '0;
    MODE = '0;
    WIDTH = '0;
    {errors, num_checks, idx} = '0;
    repeat (3) @(negedge CLK);
    NRST = 1'b1;
    for (int w = 0; w < 4; w++) begin
      start(cfgl_pkg::MODE_ACTIVE, 3'(w), w[0], 1'b0);
      finish_load(1'b0, 1 << w);
    end
    start(cfgl_pkg::MODE_ACTIVE, 3'h4, 1'b0, 1'b0);
    finish_load(1'b1, 0);
    start(2'h3, 3'h0, 1'b0, 1'b0);
    finish_load(1'b1, 0);
    for (int w = 0; w < 6; w++) begin
      start(cfgl_pkg::MODE_PASSIVE, 3'(w), 1'b0, 1'(w < 2));
      repeat (3200) @(negedge CLK);
      feed(1 << w, 1'b0);
      finish_load(1'b0, 0);
      if (w > 3) begin
        start(cfgl_pkg::MODE_PASSIVE, 3'(w), 1'b0, 1'b1);
        finish_load(1'b1, 0);
      end
    end
    start(cfgl_pkg::MODE_JTAG, cfgl_pkg::WIDTH_X1, 1'b0, 1'b0);
    feed(1, 1'b1);
    finish_load(1'b0, 0);
    results();
  end
endmodule : cfgl_loader_tb
`default_nettype wire
